// File: core/vectored_priority_interrupt_controller.sv
/*
 * Vectored priority interrupt controller with an APB register slave.
 * Assumes peripherals give one-cycle event pulses synchronous to pclk and
 * the core pulses irq_ack when it takes the presented vector.
 */
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module vectored_priority_interrupt_controller (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral events, bit n is flag bit n, bit 0 unused
	input wire logic [14:0] source_events,
	input wire logic external_request_zero,
	input wire logic [3:0] trap_events,
	// Core handshake
	input wire logic irq_ack,
	input wire logic trap_return,
	output logic irq_request,
	output logic [6:0] pending_vector_number,
	output logic [3:0] pending_priority_level,
	output logic alternate_vector_table
);

	localparam int N = irq_ctrl_pkg::NUM_SOURCES;
	localparam int PW = irq_ctrl_pkg::PRIO_WIDTH;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [N-1:0] flags;
		logic [N-1:0] enables;
		logic [N*PW-1:0] prios;
		logic nesting_disable;
		logic [3:0] trap_flags;
		logic alt_table;
		logic ext_zero_falling;
		logic ext_prev;
		logic [2:0] cpu_priority_low_bits;
		logic cpu_priority_top_bit;
		logic irq_request;
		logic [6:0] vector;
		logic [3:0] level;
	} ctl_state_type;

	ctl_state_type st;
	ctl_state_type next_st;

	logic found;
	logic [6:0] win_index;
	logic [3:0] win_level;

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	prio_select #(
		.N(N),
		.PW(PW)
	) u_select (
		.flags(st.flags),
		.enables(st.enables),
		.prios(st.prios),
		.cpu_level({st.cpu_priority_top_bit, st.cpu_priority_low_bits}),
		.found(found),
		.index(win_index),
		.level(win_level)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic setup;
	logic wr;
	logic ext_edge;
	logic [N-1:0] events;
	logic [15:0] rd;
	logic hit;

	assign setup = psel && !penable;
	assign wr = psel && penable && st.pready && pwrite;
	assign ext_edge = st.ext_zero_falling ? (st.ext_prev && !external_request_zero)
		: (!st.ext_prev && external_request_zero);
	assign events = {source_events[14:1], ext_edge};

	always_comb
	begin
		next_st = st;
		rd = 16'h0000;
		hit = 1'b1;
		next_st.ext_prev = external_request_zero;
		// A software write of zero clears a flag; an event in the same cycle wins.
		if (wr && paddr == irq_ctrl_pkg::ADDR_FLAG_BASE)
			next_st.flags = pwdata[N-1:0] | events;
		else
			next_st.flags = st.flags | events;
		next_st.trap_flags = st.trap_flags | trap_events;
		if (wr)
		begin
			unique case (paddr)
				irq_ctrl_pkg::ADDR_CONTROL_A:
				begin
					next_st.nesting_disable = pwdata[irq_ctrl_pkg::NESTING_DISABLE_BIT];
					next_st.trap_flags = (pwdata[irq_ctrl_pkg::TRAP_FLAG_LSB +: 4] & st.trap_flags)
						| trap_events;
				end
				irq_ctrl_pkg::ADDR_CONTROL_B:
				begin
					next_st.alt_table = pwdata[irq_ctrl_pkg::ALT_TABLE_BIT];
					next_st.ext_zero_falling = pwdata[irq_ctrl_pkg::EXT_ZERO_EDGE_BIT];
				end
				irq_ctrl_pkg::ADDR_ENABLE_BASE:
					next_st.enables = pwdata[N-1:0];
				irq_ctrl_pkg::ADDR_CPU_STATUS:
					next_st.cpu_priority_low_bits = pwdata[irq_ctrl_pkg::CPU_PRIO_LSB +: 3];
				default:
				begin
					for (int r = 0; r < 4; r++)
					begin
						if (paddr == irq_ctrl_pkg::ADDR_PRIO_BASE + 8'(4 * r))
						begin
							for (int s = 0; s < irq_ctrl_pkg::PRIO_PER_REG; s++)
							begin
								if (r * 4 + s < N)
									next_st.prios[(r * 4 + s) * PW +: PW] =
										pwdata[s * irq_ctrl_pkg::PRIO_SLOT +: PW];
							end
						end
					end
				end
			endcase
		end
		// Taking a vector raises the CPU level; with nesting off it goes to the top.
		if (irq_ack && st.irq_request)
			next_st.cpu_priority_low_bits = st.nesting_disable ? 3'h7 : st.level[2:0];
		// The top bit only moves by trap hardware, so software cannot mask traps.
		if (|trap_events)
			next_st.cpu_priority_top_bit = 1'b1;
		else if (trap_return)
			next_st.cpu_priority_top_bit = 1'b0;
		next_st.irq_request = found;
		next_st.vector = found ? 7'(irq_ctrl_pkg::VECTOR_BASE + win_index) : 7'h00;
		next_st.level = found ? win_level : 4'h0;

		// Read decode; banks beyond the implemented sources read as zero.
		if (paddr == irq_ctrl_pkg::ADDR_CONTROL_A)
			rd = {st.nesting_disable, 10'h000, st.trap_flags, 1'b0};
		else if (paddr == irq_ctrl_pkg::ADDR_CONTROL_B)
			rd = {st.alt_table, 14'h0000, st.ext_zero_falling};
		else if (paddr == irq_ctrl_pkg::ADDR_FLAG_BASE)
			rd = {1'b0, st.flags};
		else if (paddr == irq_ctrl_pkg::ADDR_ENABLE_BASE)
			rd = {1'b0, st.enables};
		else if (paddr == irq_ctrl_pkg::ADDR_PENDING)
			rd = {4'h0, st.level, 1'b0, st.vector};
		else if (paddr == irq_ctrl_pkg::ADDR_CPU_STATUS)
			rd = {8'h00, st.cpu_priority_low_bits, 5'h00};
		else if (paddr == irq_ctrl_pkg::ADDR_CORE_CONTROL)
			rd = {12'h000, st.cpu_priority_top_bit, 3'h0};
		else if (paddr[1:0] == 2'h0 && paddr >= irq_ctrl_pkg::ADDR_FLAG_BASE
			&& paddr < irq_ctrl_pkg::ADDR_PENDING)
		begin
			// Remaining bank words of the thirty-two-register map.
			for (int r = 0; r < 4; r++)
			begin
				if (paddr == irq_ctrl_pkg::ADDR_PRIO_BASE + 8'(4 * r))
				begin
					for (int s = 0; s < irq_ctrl_pkg::PRIO_PER_REG; s++)
					begin
						if (r * 4 + s < N)
							rd[s * irq_ctrl_pkg::PRIO_SLOT +: PW] =
								st.prios[(r * 4 + s) * PW +: PW];
					end
				end
			end
		end
		else
			hit = 1'b0;

		// One wait-free access phase: answer is ready in the first access cycle.
		next_st.pready = setup;
		next_st.pslverr = setup && !hit;
		next_st.prdata = (setup && !pwrite) ? {16'h0000, rd} : 32'h00000000;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.prios <= {N{irq_ctrl_pkg::PRIO_RESET}};
			st.cpu_priority_low_bits <= irq_ctrl_pkg::CPU_PRIO_RESET;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq_request = st.irq_request;
	assign pending_vector_number = st.vector;
	assign pending_priority_level = st.level;
	assign alternate_vector_table = st.alt_table;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence write_to(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence

	logic [3:0] cpu_lvl;
	assign cpu_lvl = {st.cpu_priority_top_bit, st.cpu_priority_low_bits};

	flag_set_a: assert property (source_events[3] |=> st.flags[3])
		else $error("event did not set its flag");
	flag_hold_a: assert property ($fell(st.flags[5]) |-> $past(wr))
		else $error("flag cleared without a software write");
	enable_gate_a: assert property (irq_request
		|-> |($past(st.enables) & (15'h0001 << (pending_vector_number - 7'h08))))
		else $error("vector presented for a disabled source");
	level_above_a: assert property (irq_request |-> pending_priority_level > $past(cpu_lvl))
		else $error("presented level not above cpu level");
	vector_range_a: assert property (irq_request |-> pending_vector_number >= 7'h08
		&& pending_vector_number < 7'h17 && pending_priority_level[3] == 1'b0)
		else $error("vector or level outside range");
	level_write_a: assert property (write_to(irq_ctrl_pkg::ADDR_CPU_STATUS) ##0 !irq_ack
		|=> st.cpu_priority_low_bits == $past(pwdata[7:5]))
		else $error("cpu level write not taken");
	top_bit_ro_a: assert property (write_to(irq_ctrl_pkg::ADDR_CORE_CONTROL)
		##0 (trap_events == 4'h0 && !trap_return) |=> $stable(st.cpu_priority_top_bit))
		else $error("software changed read-only level bit");
	flag_top_zero_a: assert property (pready && !pwrite
		&& paddr == irq_ctrl_pkg::ADDR_FLAG_BASE |-> prdata[15] == 1'b0)
		else $error("flag bit 15 read as one");
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("answer not one cycle after setup");

	// ----------------------------------------------------------------
	// Multi-step behaviour
	// ----------------------------------------------------------------
	sequence ack_taken;
		irq_ack && irq_request;
	endsequence

	sequence ext_rise;
		!external_request_zero ##1 (external_request_zero && !st.ext_zero_falling);
	endsequence

	sequence ext_fall;
		external_request_zero ##1 (!external_request_zero && st.ext_zero_falling);
	endsequence

	ack_level_a: assert property (ack_taken ##0 !st.nesting_disable
		|=> st.cpu_priority_low_bits == $past(pending_priority_level[2:0]))
		else $error("taken vector did not set the cpu level");
	nest_off_a: assert property (ack_taken ##0 st.nesting_disable
		|=> st.cpu_priority_low_bits == 3'h7)
		else $error("nesting disable did not raise the cpu level to the top");
	trap_level_a: assert property (trap_events != 4'h0 |=> st.cpu_priority_top_bit)
		else $error("trap did not raise the top level bit");
	trap_flag_a: assert property (trap_events[0] |=> st.trap_flags[0])
		else $error("trap event did not set its flag");
	ext_rise_a: assert property (ext_rise |=> st.flags[0])
		else $error("rising edge on external request zero missed");
	ext_fall_a: assert property (ext_fall |=> st.flags[0])
		else $error("falling edge on external request zero missed");
	enable_write_a: assert property (write_to(irq_ctrl_pkg::ADDR_ENABLE_BASE)
		|=> st.enables == $past(pwdata[N-1:0]))
		else $error("enable write not taken");
	prio_write_a: assert property (write_to(irq_ctrl_pkg::ADDR_PRIO_BASE)
		|=> st.prios[PW-1:0] == $past(pwdata[PW-1:0]))
		else $error("priority write not taken");
	flag_write_a: assert property (write_to(irq_ctrl_pkg::ADDR_FLAG_BASE)
		##0 (events == 15'h0000) |=> st.flags == $past(pwdata[N-1:0]))
		else $error("flag write not taken");
	alt_table_a: assert property (write_to(irq_ctrl_pkg::ADDR_CONTROL_B)
		|=> alternate_vector_table == $past(pwdata[irq_ctrl_pkg::ALT_TABLE_BIT]))
		else $error("alternate table select not taken");
	idle_vector_a: assert property (!irq_request
		|-> pending_vector_number == 7'h00 && pending_priority_level == 4'h0)
		else $error("vector shown with no request");
	bad_addr_a: assert property (psel && !penable
		&& paddr > irq_ctrl_pkg::ADDR_CORE_CONTROL |=> pready && pslverr)
		else $error("unmapped address not refused");

endmodule : vectored_priority_interrupt_controller

// File: core/irq_ctrl_pkg.sv
/*
 * Constants shared by the vectored priority interrupt controller: the APB
 * register map, field positions, reset values and vector numbering.
 * Assumes a 32-bit APB with byte addresses; registers sit in the low 16 bits.
 */
package irq_ctrl_pkg;

	// ----------------------------------------------------------------
	// Source layout
	// ----------------------------------------------------------------
	localparam int NUM_SOURCES = 15;
	localparam int PRIO_WIDTH = 3;
	localparam int PRIO_PER_REG = 4;
	localparam int PRIO_SLOT = 4;
	localparam logic [6:0] VECTOR_BASE = 7'h08;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
	localparam logic [7:0] ADDR_FLAG_BASE = 8'h08;
	localparam logic [7:0] ADDR_ENABLE_BASE = 8'h1c;
	localparam logic [7:0] ADDR_PRIO_BASE = 8'h30;
	localparam logic [7:0] ADDR_PENDING = 8'h74;
	localparam logic [7:0] ADDR_CPU_STATUS = 8'h78;
	localparam logic [7:0] ADDR_CORE_CONTROL = 8'h7c;
	localparam int FLAG_REGS = 5;
	localparam int ENABLE_REGS = 5;
	localparam int PRIO_REGS = 17;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NESTING_DISABLE_BIT = 15;
	localparam int TRAP_FLAG_LSB = 1;
	localparam int TRAP_COUNT = 4;
	localparam int ALT_TABLE_BIT = 15;
	localparam int EXT_ZERO_EDGE_BIT = 0;
	localparam int CPU_PRIO_LSB = 5;
	localparam int CPU_PRIO_TOP_BIT = 3;
	localparam int PENDING_LEVEL_LSB = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] PRIO_RESET = 3'h4;
	localparam logic [2:0] CPU_PRIO_RESET = 3'h0;

endpackage : irq_ctrl_pkg

// File: core/prio_select.sv
/*
 * Combinational winner selection among pending interrupt sources.
 * Assumes per-source request, enable and priority arrive as flat vectors.
 */
`timescale 1ns/1ps
module prio_select #(
	parameter int N = 15,
	parameter int PW = 3
) (
	// Source state
	input wire logic [N-1:0] flags,
	input wire logic [N-1:0] enables,
	input wire logic [N*PW-1:0] prios,
	// Current CPU level
	input wire logic [PW:0] cpu_level,
	// Result
	output logic found,
	output logic [6:0] index,
	output logic [PW:0] level
);

	logic [N-1:0] eligible;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : gen_elig
			assign eligible[g] = flags[g] & enables[g] &
				({1'b0, prios[g*PW +: PW]} > cpu_level);
		end
	endgenerate

	// Scanning downward with >= makes the lowest vector win a tie.
	always_comb
	begin
		found = 1'b0;
		index = 7'h00;
		level = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (eligible[i] && (!found || {1'b0, prios[i*PW +: PW]} >= level))
			begin
				found = 1'b1;
				index = 7'(i);
				level = {1'b0, prios[i*PW +: PW]};
			end
		end
	end

endmodule : prio_select

// File: bench/core_model.sv
/*
 * Behavioural model of the processor core that takes presented vectors.
 * Assumes irq_request is a registered level synchronous to pclk.
 */
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Core handshake
	input wire logic irq_request,
	input wire logic take_enable,
	output logic irq_ack
);
	logic [1:0] holdoff;

	// ----------------------------------------------------------------
	// Acknowledge
	// ----------------------------------------------------------------
	// A hold-off follows each acknowledge, since the request only drops
	// one edge after the new level lands; acking again would nest wrongly.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_ack <= 1'b0;
			holdoff <= 2'h0;
		end
		else if (holdoff != 2'h0)
		begin
			irq_ack <= 1'b0;
			holdoff <= holdoff - 2'h1;
		end
		else
		begin
			irq_ack <= take_enable & irq_request;
			holdoff <= (take_enable & irq_request) ? 2'h3 : 2'h0;
		end
	end
endmodule : core_model

// File: bench/testbench.sv
/*
 * Self-checking testbench for the interrupt controller over APB.
 * Assumes the one-cycle APB answer and register map of the controller package.
 */
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ext_zero = 1'b0, trap_return = 1'b0, take = 1'b0;
	logic [14:0] events = 15'h0;
	logic [3:0] traps = 4'h0;
	logic irq_ack, irq_request, alt_table;
	logic [6:0] vector;
	logic [3:0] level;
	logic [31:0] rdata;
	logic err;
	int num_errors = 0, total_checks = 0;

	always #5 pclk = ~pclk;

	vectored_priority_interrupt_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_events(events),
		.external_request_zero(ext_zero), .trap_events(traps), .irq_ack(irq_ack),
		.trap_return(trap_return), .irq_request(irq_request),
		.pending_vector_number(vector), .pending_priority_level(level),
		.alternate_vector_table(alt_table));
	core_model core (.pclk(pclk), .presetn(presetn), .irq_request(irq_request),
		.take_enable(take), .irq_ack(irq_ack));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			check("pready", 32'(pready), 32'h1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check($sformatf("register %h", a), rdata, exp);
	endtask : rd

	task pulse_event(input int idx);
		@(posedge pclk);
		events <= 15'h1 << idx;
		@(posedge pclk);
		events <= 15'h0;
	endtask : pulse_event

	task summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h0);
		rd(irq_ctrl_pkg::ADDR_PRIO_BASE, 32'h4444);
		rd(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'h0);
		rd(irq_ctrl_pkg::ADDR_PENDING, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		check("unmapped error", 32'(err), 32'h1);
		wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'hffff);
		rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h7fff);
		wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h0);
		for (int n = 1; n < 15; n++)
		begin
			pulse_event(n);
			rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h1 << n);
			wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h0);
		end
		@(posedge pclk);
		ext_zero <= 1'b1;
		rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h1);
		ext_zero <= 1'b0;
		wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h0);
		wr(irq_ctrl_pkg::ADDR_ENABLE_BASE, 32'h000a);
		rd(irq_ctrl_pkg::ADDR_ENABLE_BASE, 32'h000a);
		wr(irq_ctrl_pkg::ADDR_PRIO_BASE, 32'h6464);
		rd(irq_ctrl_pkg::ADDR_PRIO_BASE, 32'h6464);
		pulse_event(3);
		repeat (3) @(posedge pclk);
		check("irq vector", 32'({irq_request, level, 1'b0, vector}), 32'h160b);
		pulse_event(1);
		repeat (3) @(posedge pclk);
		check("tie vector", 32'(vector), 32'h9);
		rd(irq_ctrl_pkg::ADDR_PENDING, 32'h0609);
		wr(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'hc0);
		rd(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'hc0);
		check("masked", 32'(irq_request), 32'h0);
		wr(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'h0);
		@(posedge pclk);
		traps <= 4'h1;
		@(posedge pclk);
		traps <= 4'h0;
		rd(irq_ctrl_pkg::ADDR_CONTROL_A, 32'h0002);
		wr(irq_ctrl_pkg::ADDR_CORE_CONTROL, 32'h0);
		rd(irq_ctrl_pkg::ADDR_CORE_CONTROL, 32'h0008);
		check("trap masks", 32'(irq_request), 32'h0);
		@(posedge pclk);
		trap_return <= 1'b1;
		@(posedge pclk);
		trap_return <= 1'b0;
		rd(irq_ctrl_pkg::ADDR_CORE_CONTROL, 32'h0);
		wr(irq_ctrl_pkg::ADDR_CONTROL_A, 32'h0);
		take <= 1'b1;
		repeat (4) @(posedge pclk);
		take <= 1'b0;
		rd(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'hc0);
		check("acked", 32'(irq_request), 32'h0);
		rd(irq_ctrl_pkg::ADDR_CONTROL_A, 32'h0);
		wr(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'h0);
		wr(irq_ctrl_pkg::ADDR_CONTROL_A, 32'h8000);
		rd(irq_ctrl_pkg::ADDR_CONTROL_A, 32'h8000);
		take <= 1'b1;
		repeat (4) @(posedge pclk);
		take <= 1'b0;
		rd(irq_ctrl_pkg::ADDR_CPU_STATUS, 32'he0);
		wr(irq_ctrl_pkg::ADDR_CONTROL_B, 32'h8001);
		repeat (2) @(posedge pclk);
		check("alternate table", 32'(alt_table), 32'h1);
		rd(irq_ctrl_pkg::ADDR_CONTROL_B, 32'h8001);
		ext_zero <= 1'b1;
		rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h000a);
		ext_zero <= 1'b0;
		rd(irq_ctrl_pkg::ADDR_FLAG_BASE, 32'h000b);
		summarize();
	end

	// Runs far beyond the expected few thousand nanoseconds of traffic.
	initial
	begin
		#200000;
		num_errors++;
		summarize();
	end
endmodule : testbench
